// *** ucs_uart.sv ***
// ucs_uart: control, status and data registers of an asynchronous serial
// transceiver with four-deep transmit and receive buffers.
// assumes register strobes and pins synchronous to clock; pin drive is
// resolved outside from the active-low output enables.
// Summary of operation
// - module enable gives the block its pins; cleared, pins released and idle
// - stop-in-idle halts the block while the processor idles
// - alternate select moves transfers to alternate pins; reads zero without config
// - wake enable wakes from sleep on a start bit
// - loopback select routes transmit output back into receiver
// - baud detect routes receive pin to capture input, else capture pin
// - frame format: 9 bits none, 8 odd, 8 even, 8 none
// - stop count picks two stop bits when set, one when clear
// - transmit interrupt on every load, or only when buffer empties
// - break forces the transmit pin low except in sleep, where the pin stays high
// - transmit enable drives pin; clearing aborts and resets transmit buffer
// - transmit full reads one when buffer holds four characters
// - shift empty reads one only with shifter and buffer empty
// - receive interrupt at four, three, or every received character
// - address detect in 9-bit mode keeps only characters with bit 8 set
// - receiver idle reads one while no character is being received
// - parity error reflects the head character of receive buffer
// - framing error reflects the head character of receive buffer
// - overrun sets on overflow; software clear empties buffer and shifter
// - data available reads one while receive buffer is not empty
// - receive data returns head character, ninth bit in bit 8
// - baud divisor is 16-bit read/write, reset zero
// - bit rate is clock over sixteen times divisor plus one
// - sleep aborts transfers, drives transmit high, keeps registers
// - wake-up falling edge raises receive interrupt regardless of mode
//
// Design decisions made here: the strobed register port and the register offsets.
module ucs_uart (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rdata,
   input wire logic alternate_pin_config,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   input wire logic serial_in_pin,
   input wire logic alt_serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe_n,
   output logic alt_serial_out_pin,
   output logic alt_serial_out_oe_n,
   input wire logic capture_pin,
   output logic capture_input,
   output logic tx_irq,
   output logic rx_irq,
   output logic wake_request
);

   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} ucs_tx_state_t;
   typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100}
      ucs_rx_state_t;

   logic module_enable, stop_in_idle, alternate_pin_select, wake_enable;
   logic loopback_select, baud_detect_enable, stop_count;
   logic [1:0] frame_format;
   logic tx_interrupt_mode, tx_break, tx_enable, address_detect, overrun_error;
   logic [1:0] rx_interrupt_mode;
   logic [15:0] baud_divisor_value;

   logic wr_mode, wr_status, wr_tx, rd_rx;
   logic run, halt, tick, alt_active, nine_bit, has_parity, odd_parity;
   logic [15:0] brg_count;

   ucs_tx_state_t tx_state;
   logic [8:0] tx_mem [4];
   logic [1:0] tx_wp, tx_rp;
   logic [2:0] tx_count, next_tx_count;
   logic tx_push, tx_load, tx_line, tx_full, shift_empty;
   logic [11:0] tx_shift;
   logic [3:0] tx_bits_left, tx_phase;

   ucs_rx_state_t rx_state;
   ucs_pkg::ucs_rx_entry_t rx_mem [4];
   ucs_pkg::ucs_rx_entry_t rx_head, rx_entry;
   logic [1:0] rx_wp, rx_rp;
   logic [2:0] rx_count, next_rx_count;
   logic [3:0] rx_phase, rx_bit_idx, rx_data_bits;
   logic [8:0] rx_shift;
   logic rx_pin, rx_line, rx_pin_prev, rx_done, rx_keep, rx_push, rx_pop;
   logic overflow, overrun_clear, flush, wake_event, receiver_idle;
   logic [15:0] next_rdata;

   assign wr_mode = wr_en && addr == ucs_pkg::ADDR_MODE;
   assign wr_status = wr_en && addr == ucs_pkg::ADDR_STATUS;
   assign wr_tx = wr_en && addr == ucs_pkg::ADDR_TXDATA;
   assign rd_rx = rd_en && addr == ucs_pkg::ADDR_RXDATA;

   // sleep, disable and idle-stop all freeze the bit clock
   assign halt = ~module_enable | cpu_sleep;
   assign run = ~halt & ~(stop_in_idle & cpu_idle);
   assign alt_active = alternate_pin_select & alternate_pin_config;
   assign nine_bit = frame_format == ucs_pkg::FMT_9_NONE;
   assign has_parity = frame_format == ucs_pkg::FMT_8_ODD ||
                       frame_format == ucs_pkg::FMT_8_EVEN;
   assign odd_parity = frame_format == ucs_pkg::FMT_8_ODD;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {module_enable, stop_in_idle, alternate_pin_select, wake_enable} <= 4'h0;
         {loopback_select, baud_detect_enable, stop_count} <= 3'h0;
         frame_format <= 2'h0;
      end
      else if (wr_mode)
      begin
         module_enable <= wdata[ucs_pkg::MODE_ENABLE];
         stop_in_idle <= wdata[ucs_pkg::MODE_STOP_IDLE];
         alternate_pin_select <= wdata[ucs_pkg::MODE_ALT_PINS] & alternate_pin_config;
         wake_enable <= wdata[ucs_pkg::MODE_WAKE];
         loopback_select <= wdata[ucs_pkg::MODE_LOOPBACK];
         baud_detect_enable <= wdata[ucs_pkg::MODE_BAUD_DETECT];
         frame_format <= wdata[ucs_pkg::MODE_FORMAT_HI:ucs_pkg::MODE_FORMAT_LO];
         stop_count <= wdata[ucs_pkg::MODE_STOP_COUNT];
      end
   end

   assign overflow = rx_done && rx_keep && rx_count == ucs_pkg::BUF_DEPTH;
   assign overrun_clear = wr_status && !wdata[ucs_pkg::STA_OVERRUN] && overrun_error;
   // an overflow in the clearing cycle keeps the flag and the buffer
   assign flush = overrun_clear && !overflow;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {tx_interrupt_mode, tx_break, tx_enable, address_detect} <= 4'h0;
         rx_interrupt_mode <= 2'h0;
      end
      else if (wr_status)
      begin
         tx_interrupt_mode <= wdata[ucs_pkg::STA_TX_IRQ_MODE];
         tx_break <= wdata[ucs_pkg::STA_TX_BREAK];
         tx_enable <= wdata[ucs_pkg::STA_TX_ENABLE];
         rx_interrupt_mode <= wdata[ucs_pkg::STA_RX_IRQ_HI:ucs_pkg::STA_RX_IRQ_LO];
         address_detect <= wdata[ucs_pkg::STA_ADDR_DETECT];
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         overrun_error <= 1'b0;
      else if (overflow)
         overrun_error <= 1'b1;
      else if (overrun_clear)
         overrun_error <= 1'b0;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         baud_divisor_value <= ucs_pkg::BAUD_RESET;
      else if (wr_en && addr == ucs_pkg::ADDR_BAUD)
         baud_divisor_value <= wdata;
   end

   // one tick per divisor+1 clocks; sixteen ticks per bit
   assign tick = run && brg_count == baud_divisor_value;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         brg_count <= 16'h0000;
      else if (!run || tick)
         brg_count <= 16'h0000;
      else
         brg_count <= brg_count + 16'h0001;
   end

   // transmit buffer
   assign tx_full = tx_count == ucs_pkg::BUF_DEPTH;
   assign tx_push = wr_tx && module_enable && tx_enable && !tx_full;
   assign tx_load = tx_state == TX_IDLE && tx_count != 3'h0 && run && tx_enable;
   assign next_tx_count = tx_count + {2'b00, tx_push} - {2'b00, tx_load};
   assign shift_empty = tx_state == TX_IDLE && tx_count == 3'h0;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_count <= 3'h0;
         tx_wp <= 2'h0;
         tx_rp <= 2'h0;
      end
      else if (!tx_enable)
      begin
         tx_count <= 3'h0;
         tx_wp <= 2'h0;
         tx_rp <= 2'h0;
      end
      else
      begin
         tx_count <= next_tx_count;
         if (tx_push)
            tx_wp <= tx_wp + 2'h1;
         if (tx_load)
            tx_rp <= tx_rp + 2'h1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (tx_push)
         tx_mem[tx_wp] <= wdata[8:0];
   end

   // frame image, start bit in bit 0; spare upper bits stay high as stop bits
   function automatic logic [11:0] ucs_frame(input logic [8:0] d, input logic [1:0] fmt);
      logic [11:0] f;
      f = 12'hfff;
      f[0] = 1'b0;
      f[8:1] = d[7:0];
      if (fmt == ucs_pkg::FMT_9_NONE)
         f[9] = d[8];
      else if (fmt == ucs_pkg::FMT_8_ODD)
         f[9] = ~^d[7:0];
      else if (fmt == ucs_pkg::FMT_8_EVEN)
         f[9] = ^d[7:0];
      return f;
   endfunction

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_state <= TX_IDLE;
         tx_shift <= 12'hfff;
         tx_bits_left <= 4'h0;
         tx_phase <= 4'h0;
      end
      else if (halt || !tx_enable)
      begin
         tx_state <= TX_IDLE;
         tx_shift <= 12'hfff;
         tx_phase <= 4'h0;
      end
      else
      begin
         unique case (tx_state)
            TX_IDLE:
               if (tx_load)
               begin
                  tx_state <= TX_SHIFT;
                  tx_shift <= ucs_frame(tx_mem[tx_rp], frame_format);
                  tx_bits_left <= ucs_pkg::FRAME_BASE_BITS
                     + {3'b000, nine_bit | has_parity} + {3'b000, stop_count};
                  tx_phase <= 4'h0;
               end
            TX_SHIFT:
               if (tick)
               begin
                  tx_phase <= tx_phase + 4'h1;
                  if (tx_phase == ucs_pkg::SAMPLE_LAST)
                  begin
                     tx_shift <= {1'b1, tx_shift[11:1]};
                     tx_bits_left <= tx_bits_left - 4'h1;
                     if (tx_bits_left == 4'h1)
                        tx_state <= TX_IDLE;
                  end
               end
         endcase
      end
   end

   assign tx_line = tx_state == TX_SHIFT ? tx_shift[0] : 1'b1;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         tx_irq <= 1'b0;
      else
         tx_irq <= tx_load && (!tx_interrupt_mode || next_tx_count == 3'h0);
   end

   // pin outputs; loopback keeps the outside line idle high
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_out_pin <= 1'b1;
         alt_serial_out_pin <= 1'b1;
         serial_out_oe_n <= 1'b1;
         alt_serial_out_oe_n <= 1'b1;
      end
      else
      begin
         serial_out_oe_n <= !(module_enable && tx_enable && !alt_active);
         alt_serial_out_oe_n <= !(module_enable && tx_enable && alt_active);
         if (cpu_sleep)
         begin
            serial_out_pin <= 1'b1;
            alt_serial_out_pin <= 1'b1;
         end
         else
         begin
            serial_out_pin <= !tx_break && (loopback_select || tx_line);
            alt_serial_out_pin <= !tx_break && (loopback_select || tx_line);
         end
      end
   end

   // receive side
   assign rx_pin = alt_active ? alt_serial_in_pin : serial_in_pin;
   assign rx_line = loopback_select ? tx_line : rx_pin;
   assign rx_data_bits = (nine_bit || has_parity) ? ucs_pkg::DATA_BITS_9
                                                   : ucs_pkg::DATA_BITS_8;
   assign rx_done = rx_state == RX_DATA && tick && rx_phase == ucs_pkg::SAMPLE_LAST &&
                    rx_bit_idx == rx_data_bits;
   // characters without the address bit are dropped while address detect is on in 9-bit mode
   assign rx_keep = !(nine_bit && address_detect && !rx_shift[8]);
   assign rx_push = rx_done && rx_keep && rx_count != ucs_pkg::BUF_DEPTH;
   assign rx_pop = rd_rx && rx_count != 3'h0;
   assign next_rx_count = rx_count + {2'b00, rx_push} - {2'b00, rx_pop};
   assign receiver_idle = rx_state == RX_IDLE;

   always_comb
   begin
      rx_entry.data = nine_bit ? rx_shift : {1'b0, rx_shift[7:0]};
      rx_entry.framing_error = !rx_line;
      rx_entry.parity_error = has_parity && ((^rx_shift) == odd_parity ? 1'b0 : 1'b1);
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_state <= RX_IDLE;
         rx_phase <= 4'h0;
         rx_bit_idx <= 4'h0;
         rx_shift <= 9'h000;
      end
      else if (halt || flush)
      begin
         rx_state <= RX_IDLE;
         rx_phase <= 4'h0;
         rx_bit_idx <= 4'h0;
         rx_shift <= 9'h000;
      end
      else if (run)
      begin
         unique case (rx_state)
            RX_IDLE:
               if (!rx_line)
               begin
                  rx_state <= RX_START;
                  rx_phase <= 4'h0;
               end
            RX_START:
               if (tick)
               begin
                  rx_phase <= rx_phase + 4'h1;
                  if (rx_phase == ucs_pkg::START_MID)
                  begin
                     rx_state <= rx_line ? RX_IDLE : RX_DATA;
                     rx_phase <= 4'h0;
                     rx_bit_idx <= 4'h0;
                     rx_shift <= 9'h000;
                  end
               end
            RX_DATA:
               if (tick)
               begin
                  rx_phase <= rx_phase + 4'h1;
                  if (rx_phase == ucs_pkg::SAMPLE_LAST)
                  begin
                     if (rx_bit_idx == rx_data_bits)
                        rx_state <= RX_IDLE;
                     else
                     begin
                        rx_shift[rx_bit_idx] <= rx_line;
                        rx_bit_idx <= rx_bit_idx + 4'h1;
                     end
                  end
               end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_count <= 3'h0;
         rx_wp <= 2'h0;
         rx_rp <= 2'h0;
      end
      else if (flush)
      begin
         rx_count <= 3'h0;
         rx_wp <= 2'h0;
         rx_rp <= 2'h0;
      end
      else
      begin
         rx_count <= next_rx_count;
         if (rx_push)
            rx_wp <= rx_wp + 2'h1;
         if (rx_pop)
            rx_rp <= rx_rp + 2'h1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rx_push)
         rx_mem[rx_wp] <= rx_entry;
   end

   assign rx_head = rx_count != 3'h0 ? rx_mem[rx_rp] : '0;

   // wake edge seen on the pin itself, loopback does not apply asleep
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rx_pin_prev <= 1'b1;
      else
         rx_pin_prev <= rx_pin;
   end

   assign wake_event = cpu_sleep && wake_enable && module_enable &&
                       rx_pin_prev && !rx_pin;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_irq <= 1'b0;
         wake_request <= 1'b0;
      end
      else
      begin
         wake_request <= wake_event;
         unique case (rx_interrupt_mode)
            ucs_pkg::RXI_FULL:
               rx_irq <= wake_event ||
                  (rx_push && next_rx_count == ucs_pkg::BUF_DEPTH);
            ucs_pkg::RXI_THREE:
               rx_irq <= wake_event || (rx_push && next_rx_count == ucs_pkg::BUF_THREE);
            default:
               rx_irq <= wake_event || rx_push;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         capture_input <= 1'b1;
      else
         capture_input <= baud_detect_enable ? rx_pin : capture_pin;
   end

   // register read mux; unmapped and write-only words read zero
   always_comb
   begin
      next_rdata = 16'h0000;
      unique case (addr)
         ucs_pkg::ADDR_MODE:
         begin
            next_rdata[ucs_pkg::MODE_ENABLE] = module_enable;
            next_rdata[ucs_pkg::MODE_STOP_IDLE] = stop_in_idle;
            next_rdata[ucs_pkg::MODE_ALT_PINS] = alt_active;
            next_rdata[ucs_pkg::MODE_WAKE] = wake_enable;
            next_rdata[ucs_pkg::MODE_LOOPBACK] = loopback_select;
            next_rdata[ucs_pkg::MODE_BAUD_DETECT] = baud_detect_enable;
            next_rdata[ucs_pkg::MODE_FORMAT_HI:ucs_pkg::MODE_FORMAT_LO] = frame_format;
            next_rdata[ucs_pkg::MODE_STOP_COUNT] = stop_count;
         end
         ucs_pkg::ADDR_STATUS:
         begin
            next_rdata[ucs_pkg::STA_TX_IRQ_MODE] = tx_interrupt_mode;
            next_rdata[ucs_pkg::STA_TX_BREAK] = tx_break;
            next_rdata[ucs_pkg::STA_TX_ENABLE] = tx_enable;
            next_rdata[ucs_pkg::STA_TX_FULL] = tx_full;
            next_rdata[ucs_pkg::STA_SHIFT_EMPTY] = shift_empty;
            next_rdata[ucs_pkg::STA_RX_IRQ_HI:ucs_pkg::STA_RX_IRQ_LO] = rx_interrupt_mode;
            next_rdata[ucs_pkg::STA_ADDR_DETECT] = address_detect;
            next_rdata[ucs_pkg::STA_RX_IDLE] = receiver_idle;
            next_rdata[ucs_pkg::STA_PARITY_ERR] = rx_head.parity_error;
            next_rdata[ucs_pkg::STA_FRAMING_ERR] = rx_head.framing_error;
            next_rdata[ucs_pkg::STA_OVERRUN] = overrun_error;
            next_rdata[ucs_pkg::STA_RX_AVAIL] = rx_count != 3'h0;
         end
         ucs_pkg::ADDR_RXDATA:
            next_rdata[8:0] = rx_head.data;
         ucs_pkg::ADDR_BAUD:
            next_rdata = baud_divisor_value;
         default:
            next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 16'h0000;
      else if (rd_en)
         rdata <= next_rdata;
      else
         rdata <= 16'h0000;
   end

endmodule // ucs_uart

// *** ucs_pkg.sv ***
// ucs_pkg: register map, field positions, frame codes and reset values
// of the serial transceiver control block.
// assumes one 100 MHz clock and a plain strobe-based register port.
package ucs_pkg;

   // register word addresses on the plain register port
   localparam logic [2:0] ADDR_MODE = 3'h0;
   localparam logic [2:0] ADDR_STATUS = 3'h1;
   localparam logic [2:0] ADDR_TXDATA = 3'h2;
   localparam logic [2:0] ADDR_RXDATA = 3'h3;
   localparam logic [2:0] ADDR_BAUD = 3'h4;

   // serial_mode_control fields
   localparam int MODE_ENABLE = 15;
   localparam int MODE_STOP_IDLE = 13;
   localparam int MODE_ALT_PINS = 10;
   localparam int MODE_WAKE = 7;
   localparam int MODE_LOOPBACK = 6;
   localparam int MODE_BAUD_DETECT = 5;
   localparam int MODE_FORMAT_HI = 2;
   localparam int MODE_FORMAT_LO = 1;
   localparam int MODE_STOP_COUNT = 0;

   // serial_status_control fields
   localparam int STA_TX_IRQ_MODE = 15;
   localparam int STA_TX_BREAK = 11;
   localparam int STA_TX_ENABLE = 10;
   localparam int STA_TX_FULL = 9;
   localparam int STA_SHIFT_EMPTY = 8;
   localparam int STA_RX_IRQ_HI = 7;
   localparam int STA_RX_IRQ_LO = 6;
   localparam int STA_ADDR_DETECT = 5;
   localparam int STA_RX_IDLE = 4;
   localparam int STA_PARITY_ERR = 3;
   localparam int STA_FRAMING_ERR = 2;
   localparam int STA_OVERRUN = 1;
   localparam int STA_RX_AVAIL = 0;

   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [15:0] BAUD_RESET = 16'h0000;

   // frame_format codes
   localparam logic [1:0] FMT_9_NONE = 2'h3;
   localparam logic [1:0] FMT_8_ODD = 2'h2;
   localparam logic [1:0] FMT_8_EVEN = 2'h1;
   localparam logic [1:0] FMT_8_NONE = 2'h0;

   // rx_interrupt_mode codes
   localparam logic [1:0] RXI_FULL = 2'h3;
   localparam logic [1:0] RXI_THREE = 2'h2;

   // buffers and bit timing
   localparam logic [2:0] BUF_DEPTH = 3'h4;
   localparam logic [2:0] BUF_THREE = 3'h3;
   localparam logic [3:0] SAMPLE_LAST = 4'hf;
   localparam logic [3:0] START_MID = 4'h7;
   localparam logic [3:0] FRAME_BASE_BITS = 4'ha;
   localparam logic [3:0] DATA_BITS_8 = 4'h8;
   localparam logic [3:0] DATA_BITS_9 = 4'h9;

   typedef struct packed {
      logic parity_error;
      logic framing_error;
      logic [8:0] data;
   } ucs_rx_entry_t;

endpackage

// *** ucs_uart_monitor.sv ***
// ucs_uart_monitor: port-level checks of the serial control block.
// assumes one clock domain and the plain register port of ucs_uart.
module ucs_uart_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [15:0] rdata,
   input wire logic serial_out_pin,
   input wire logic serial_out_oe_n,
   input wire logic alt_serial_out_oe_n,
   input wire logic capture_pin,
   input wire logic capture_input,
   input wire logic tx_irq,
   input wire logic rx_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic en_sh;
   logic brk_sh;
   logic abd_sh;
   logic [15:0] baud_sh;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // shadows come from the writes alone, never from design state
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_sh <= 1'b0;
         brk_sh <= 1'b0;
         abd_sh <= 1'b0;
         baud_sh <= 16'h0000;
      end
      else if (wr_en)
      begin
         if (addr == ucs_pkg::ADDR_MODE)
         begin
            en_sh <= wdata[ucs_pkg::MODE_ENABLE];
            abd_sh <= wdata[ucs_pkg::MODE_BAUD_DETECT];
         end
         if (addr == ucs_pkg::ADDR_STATUS)
            brk_sh <= wdata[ucs_pkg::STA_TX_BREAK] & wdata[ucs_pkg::STA_TX_ENABLE];
         if (addr == ucs_pkg::ADDR_BAUD)
            baud_sh <= wdata;
      end
   end
   sequence baud_read;
      rd_en && addr == ucs_pkg::ADDR_BAUD;
   endsequence
   rdata_idle_a: assert property (!rd_en |=> rdata == 16'h0000)
      else $error("read data not zero outside answer");
   baud_readback_a: assert property (baud_read |=> rdata == baud_sh)
      else $error("divisor read differs from last write");
   rx_upper_zero_a: assert property (rd_en && addr == ucs_pkg::ADDR_RXDATA |=>
      rdata[15:9] == 7'h00) else $error("receive data upper bits not zero");
   break_low_a: assert property (brk_sh && $past(brk_sh) && en_sh && $past(en_sh)
      |-> !serial_out_pin || serial_out_oe_n) else $error("break pin not low");
   pins_released_a: assert property (!en_sh && !$past(en_sh)
      |-> serial_out_oe_n && alt_serial_out_oe_n) else $error("pins driven while off");
   capture_route_a: assert property (!abd_sh && !$past(abd_sh)
      |-> capture_input == $past(capture_pin)) else $error("capture source wrong");
   tx_pulse_a: assert property (tx_irq |=> !tx_irq)
      else $error("transmit interrupt longer than one cycle");
   rx_pulse_a: assert property (rx_irq |=> !rx_irq)
      else $error("receive interrupt longer than one cycle");
endmodule // ucs_uart_monitor

// *** ucs_remote.sv ***
// ucs_remote: far-end serial device on the transmit and receive pins.
// assumes divisor zero, so one bit lasts sixteen clocks; line idles high.
module ucs_remote #(parameter int BIT = 16) (
   input wire logic clock,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line_out = 1'b1;
   // low start, data lsb first, one high stop
   task automatic send(input logic [8:0] d, input int n);
      @(posedge clock);
      line_out <= 1'b0;
      repeat (BIT) @(posedge clock);
      for (int i = 0; i < n; i++)
      begin
         line_out <= d[i];
         repeat (BIT) @(posedge clock);
      end
      line_out <= 1'b1;
      repeat (BIT) @(posedge clock);
   endtask
   // samples mid-bit, so a wrong bit rate shows as wrong bits
   task automatic recv(output logic [10:0] d, input int n);
      d = 11'h000;
      wait (line_in === 1'b0);
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < n; i++)
      begin
         repeat (BIT) @(posedge clock);
         d[i] = line_in;
      end
   endtask
endmodule // ucs_remote

// *** ucs_uart_bench.sv ***
// ucs_uart_bench: self-checking bench of the serial control block.
// assumes ucs_remote on the pins and the monitor bound to the design.
module ucs_uart_bench;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic alternate_pin_config = 1'b0, cpu_idle = 1'b0, cpu_sleep = 1'b0;
   logic alt_serial_in_pin = 1'b1, capture_pin = 1'b0;
   logic [15:0] rdata;
   logic serial_in_pin, serial_out_pin, serial_out_oe_n, alt_serial_out_pin;
   logic alt_serial_out_oe_n, capture_input, tx_irq, rx_irq, wake_request;
   logic [10:0] got;
   int err_count = 0;
   int num_checks = 0;
   int tx_irqs = 0;
   int rx_irqs = 0;
   initial forever #5 clock = ~clock;
   always @(posedge clock) capture_pin <= ~capture_pin;
   always @(posedge clock)
   begin
      if (tx_irq === 1'b1)
         tx_irqs++;
      if (rx_irq === 1'b1)
         rx_irqs++;
   end
   ucs_uart dut (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .alternate_pin_config,
      .cpu_idle, .cpu_sleep, .serial_in_pin, .alt_serial_in_pin, .serial_out_pin,
      .serial_out_oe_n, .alt_serial_out_pin, .alt_serial_out_oe_n, .capture_pin,
      .capture_input, .tx_irq, .rx_irq, .wake_request);
   // released transmit pin reads its pull-up level
   ucs_remote remote (.clock, .line_in(serial_out_pin | serial_out_oe_n),
      .line_out(serial_in_pin));
   task automatic stop_test;
      if (err_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // a spare edge after each strobe keeps one assignment per time step
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk_rd(input logic [2:0] a, input logic [15:0] e);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(negedge clock);
      `CHK("rdata", e, rdata)
      @(posedge clock);
   endtask
   task automatic t_regs;
      chk_rd(ucs_pkg::ADDR_STATUS, 16'h0110);
      chk_rd(ucs_pkg::ADDR_MODE, 16'h0000);
      chk_rd(ucs_pkg::ADDR_BAUD, 16'h0000);
      chk_rd(3'h7, 16'h0000);
      wr(ucs_pkg::ADDR_BAUD, 16'hffff);
      chk_rd(ucs_pkg::ADDR_BAUD, 16'hffff);
      wr(ucs_pkg::ADDR_BAUD, 16'h0000);
   endtask
   task automatic t_tx;
      wr(ucs_pkg::ADDR_MODE, 16'h8002);
      wr(ucs_pkg::ADDR_STATUS, 16'h0400);
      wr(ucs_pkg::ADDR_TXDATA, 16'h00a7);
      remote.recv(got, 10);
      `CHK("frame", 11'h3a7, got)
      repeat (5) wr(ucs_pkg::ADDR_TXDATA, 16'h0055);
      chk_rd(ucs_pkg::ADDR_STATUS, 16'h0610);
      wr(ucs_pkg::ADDR_STATUS, 16'h0c00);
      repeat (2) @(posedge clock);
      `CHK("break", 1'b0, serial_out_pin)
      wr(ucs_pkg::ADDR_STATUS, 16'h0000);
      chk_rd(ucs_pkg::ADDR_STATUS, 16'h0110);
      `CHK("release", 1'b1, serial_out_oe_n)
      `CHK("tx_irq count", 2, tx_irqs)
   endtask
   task automatic t_rx;
      wr(ucs_pkg::ADDR_MODE, 16'h8006);
      remote.send(9'h1c3, 9);
      chk_rd(ucs_pkg::ADDR_STATUS, 16'h0111);
      chk_rd(ucs_pkg::ADDR_RXDATA, 16'h01c3);
      repeat (5) remote.send(9'h1c3, 9);
      chk_rd(ucs_pkg::ADDR_STATUS, 16'h0113);
      wr(ucs_pkg::ADDR_STATUS, 16'h0000);
      chk_rd(ucs_pkg::ADDR_STATUS, 16'h0110);
      chk_rd(ucs_pkg::ADDR_RXDATA, 16'h0000);
      wr(ucs_pkg::ADDR_STATUS, 16'h0020);
      remote.send(9'h033, 9);
      chk_rd(ucs_pkg::ADDR_STATUS, 16'h0130);
      wr(ucs_pkg::ADDR_MODE, 16'h8002);
      remote.send(9'h001, 9);
      chk_rd(ucs_pkg::ADDR_STATUS, 16'h0139);
      chk_rd(ucs_pkg::ADDR_RXDATA, 16'h0001);
      wr(ucs_pkg::ADDR_MODE, 16'h8000);
      remote.send(9'h000, 9);
      chk_rd(ucs_pkg::ADDR_STATUS, 16'h0135);
      wr(ucs_pkg::ADDR_MODE, 16'h8040);
      wr(ucs_pkg::ADDR_STATUS, 16'h0420);
      wr(ucs_pkg::ADDR_TXDATA, 16'h005a);
      repeat (20) @(posedge clock);
      `CHK("loop pin", 1'b1, serial_out_pin)
      repeat (180) @(posedge clock);
      chk_rd(ucs_pkg::ADDR_RXDATA, 16'h0000);
      chk_rd(ucs_pkg::ADDR_RXDATA, 16'h005a);
      `CHK("rx_irq count", 8, rx_irqs)
   endtask
   initial
   begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_tx();
      t_rx();
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      err_count++;
      stop_test();
   end
endmodule // ucs_uart_bench
bind ucs_uart ucs_uart_monitor mon (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
   .serial_out_pin, .serial_out_oe_n, .alt_serial_out_oe_n, .capture_pin, .capture_input,
   .tx_irq, .rx_irq);
